// *** src/i2c_slave_end.sv ***
// Summary of operation
// - Board selects two-wire mode via straps
// - Answer address 0x20 or 0x21 by pin
// - Never hold the clock line low
// - Work at standard and fast bus rates
// - Filter out spikes of 50 ns
// - Start makes bus busy, address follows
// - Stop ends transaction, back to idle
// - Compare seven address bits, then direction
// - Transmitter releases data in ninth clock
// - Receiver pulls data low through ack
// - No limit on bytes per transaction
// - Repeated start accepts a new address
// - Read: index write, restart, then data
// - Read pointer advances after each byte
// - Master ends read with nack, stop
// - Write: index, data, ack, then stored
// - Write pointer advances after each byte
// - Master ends a data write with stop
// - Ignore bus while core supply off
// - Pins released while core supply off
module i2c_slave_end
    import i2c_link_pkg::*;
(
    // Bus pins and the bus sampling clock
    i2c_link_if.device link,
    input  wire logic       link_clk,
    // System clock, reset and freeze
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Strap and supply levels
    input  wire logic       address_lsb_pin,
    input  wire logic       core_supply,
    input  wire logic       interface_supply,
    // Local register port
    input  wire logic       user_we,
    input  wire logic [7:0] user_index,
    input  wire logic [7:0] user_wdata,
    output logic      [7:0] user_rdata,
    // Notice of each register written from the bus
    output logic            bus_wr_pulse,
    output logic      [7:0] bus_wr_index,
    output logic      [7:0] bus_wr_data
);

    typedef enum logic [2:0] {D_IDLE, D_ADDR, D_INDEX, D_WDATA, D_ACK, D_RDATA, D_MACK, D_IGNORE} dev_state_type;

    logic          [6:0] pin_raw;
    logic          [6:0] pin_f;
    logic                scl_f;
    logic                sda_f;
    logic                lsb_f;
    logic                core_f;
    logic                io_f;
    logic                isel_f;
    logic                ssel_f;
    logic                scl_q_r;
    logic                sda_q_r;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_seen;
    logic                stop_seen;
    logic                powered;
    logic                addr_match;
    logic                byte_done;
    dev_state_type       state_r;
    dev_state_type       state_nxt;
    dev_state_type       ack_next_r;
    dev_state_type       ack_next_nxt;
    logic          [3:0] bit_r;
    logic          [3:0] bit_nxt;
    logic          [7:0] shift_r;
    logic          [7:0] shift_nxt;
    logic          [7:0] ptr_r;
    logic          [7:0] ptr_nxt;
    logic                sda_oe_r;
    logic                sda_oe_nxt;
    logic                wr_fire;
    logic                rd_fire;
    logic          [7:0] rd_index_nxt;
    logic          [7:0] rd_index_r;
    logic                wr_tog_r;
    logic          [7:0] wr_index_r;
    logic          [7:0] wr_data_r;
    logic                rd_tog_r;
    logic          [7:0] rdata_r;
    logic                rack_s1_r;
    logic                rack_s2_r;
    logic                rack_q_r;
    logic                wsync1_r;
    logic                wsync2_r;
    logic                wq_r;
    logic                rsync1_r;
    logic                rsync2_r;
    logic                rq_r;
    logic                wr_event;
    logic                rd_event;
    logic          [7:0] rd_data_c_r;
    logic                rd_ack_tog_r;
    logic          [7:0] mem [REG_COUNT];

    // Every pin passes the same filter, so clock and data keep their order
    assign pin_raw = {link.scl, link.sda, address_lsb_pin, core_supply, interface_supply,
                      link.interface_select, link.serial_select};

    for (genvar i = 0; i < 7; i++)
    begin : g_pin
        pin_filter u_filter (
            .clk   (link_clk),
            .rst_b (rst_b),
            .din   (pin_raw[i]),
            .dout  (pin_f[i])
        );
    end

    assign scl_f  = pin_f[6];
    assign sda_f  = pin_f[5];
    assign lsb_f  = pin_f[4];
    assign core_f = pin_f[3];
    assign io_f   = pin_f[2];
    assign isel_f = pin_f[1];
    assign ssel_f = pin_f[0];

    // Bus events; start and stop need the clock high in two samples
    assign scl_rise   = scl_f & ~scl_q_r;
    assign scl_fall   = ~scl_f & scl_q_r;
    assign start_seen = scl_f & scl_q_r & sda_q_r & ~sda_f;
    assign stop_seen  = scl_f & scl_q_r & ~sda_q_r & sda_f;
    assign powered    = core_f & io_f & ~isel_f & ssel_f;
    assign addr_match = shift_r[7:1] == own_address(lsb_f);
    assign byte_done  = scl_fall & (bit_r == 4'h8);

    // The clock line is never driven from this end
    assign link.dev_sda_o  = 1'h0;
    assign link.dev_sda_oe = sda_oe_r;

    // Protocol sequencer, stepped by filtered bus edges
    always_comb
    begin
        state_nxt    = state_r;
        ack_next_nxt = ack_next_r;
        bit_nxt      = bit_r;
        shift_nxt    = shift_r;
        ptr_nxt      = ptr_r;
        sda_oe_nxt   = sda_oe_r;
        wr_fire      = 1'h0;
        rd_fire      = 1'h0;
        rd_index_nxt = rd_index_r;
        if (!powered)
        begin
            state_nxt  = D_IDLE;
            sda_oe_nxt = 1'h0;
        end
        else if (stop_seen)
        begin
            state_nxt  = D_IDLE;
            sda_oe_nxt = 1'h0;
        end
        else if (start_seen)
        begin
            state_nxt  = D_ADDR;
            bit_nxt    = 4'h0;
            sda_oe_nxt = 1'h0;
        end
        else
        begin
            case (state_r)
                D_ADDR, D_INDEX, D_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_f};
                        bit_nxt   = bit_r + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        state_nxt  = D_ACK;
                        sda_oe_nxt = 1'h1;
                        bit_nxt    = 4'h0;
                        if (state_r == D_ADDR)
                        begin
                            if (!addr_match)
                            begin
                                state_nxt  = D_IGNORE;
                                sda_oe_nxt = 1'h0;
                            end
                            else if (shift_r[0])
                            begin
                                ack_next_nxt = D_RDATA;
                                rd_fire      = 1'h1;
                                rd_index_nxt = ptr_r;
                            end
                            else
                                ack_next_nxt = D_INDEX;
                        end
                        else if (state_r == D_INDEX)
                        begin
                            ptr_nxt      = shift_r;
                            ack_next_nxt = D_WDATA;
                        end
                        else
                        begin
                            wr_fire      = 1'h1;
                            ptr_nxt      = ptr_r + 8'h01;
                            ack_next_nxt = D_WDATA;
                        end
                    end
                end
                D_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_nxt  = ack_next_r;
                        bit_nxt    = 4'h0;
                        sda_oe_nxt = 1'h0;
                        if (ack_next_r == D_RDATA)
                        begin
                            shift_nxt  = rdata_r;
                            sda_oe_nxt = ~rdata_r[7];
                            bit_nxt    = 4'h1;
                        end
                    end
                end
                D_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_r == 4'h8)
                        begin
                            state_nxt  = D_MACK;
                            sda_oe_nxt = 1'h0;
                        end
                        else
                        begin
                            shift_nxt  = {shift_r[6:0], 1'h0};
                            sda_oe_nxt = ~shift_r[6];
                            bit_nxt    = bit_r + 4'h1;
                        end
                    end
                end
                D_MACK:
                begin
                    // The next byte is fetched at once; the master's ack slot
                    // high time covers the round trip to the register file
                    if (scl_rise)
                    begin
                        ptr_nxt = ptr_r + 8'h01;
                        if (sda_f)
                            state_nxt = D_IGNORE;
                        else
                        begin
                            state_nxt    = D_ACK;
                            ack_next_nxt = D_RDATA;
                            rd_fire      = 1'h1;
                            rd_index_nxt = ptr_r + 8'h01;
                        end
                    end
                end
                D_IDLE, D_IGNORE:
                    state_nxt = state_r;
                default:
                    state_nxt = D_IDLE;
            endcase
        end
    end

    // Link-domain state
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_q_r    <= 1'h1;
            sda_q_r    <= 1'h1;
            state_r    <= D_IDLE;
            ack_next_r <= D_IDLE;
            bit_r      <= 4'h0;
            shift_r    <= 8'h00;
            ptr_r      <= PTR_RESET;
            sda_oe_r   <= 1'h0;
            rd_index_r <= 8'h00;
        end
        else
        begin
            scl_q_r    <= scl_f;
            sda_q_r    <= sda_f;
            state_r    <= state_nxt;
            ack_next_r <= ack_next_nxt;
            bit_r      <= bit_nxt;
            shift_r    <= shift_nxt;
            ptr_r      <= ptr_nxt;
            sda_oe_r   <= sda_oe_nxt;
            rd_index_r <= rd_index_nxt;
        end
    end

    // Toggles carry events out; index and data hold still until seen
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_tog_r   <= 1'h0;
            wr_index_r <= 8'h00;
            wr_data_r  <= 8'h00;
            rd_tog_r   <= 1'h0;
        end
        else
        begin
            wr_tog_r <= wr_tog_r ^ wr_fire;
            rd_tog_r <= rd_tog_r ^ rd_fire;
            if (wr_fire)
            begin
                wr_index_r <= ptr_r;
                wr_data_r  <= shift_r;
            end
        end
    end

    // Read answer returns by toggle; the data word is stable by then
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rack_s1_r <= 1'h0;
            rack_s2_r <= 1'h0;
            rack_q_r  <= 1'h0;
            rdata_r   <= 8'h00;
        end
        else
        begin
            rack_s1_r <= rd_ack_tog_r;
            rack_s2_r <= rack_s1_r;
            rack_q_r  <= rack_s2_r;
            if (rack_s2_r ^ rack_q_r)
                rdata_r <= rd_data_c_r;
        end
    end

    assign wr_event = wsync2_r ^ wq_r;
    assign rd_event = rsync2_r ^ rq_r;

    // System side: catch the toggles; a missed edge under freeze is kept
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wsync1_r     <= 1'h0;
            wsync2_r     <= 1'h0;
            wq_r         <= 1'h0;
            rsync1_r     <= 1'h0;
            rsync2_r     <= 1'h0;
            rq_r         <= 1'h0;
            rd_ack_tog_r <= 1'h0;
            rd_data_c_r  <= 8'h00;
        end
        else if (clk_en)
        begin
            wsync1_r <= wr_tog_r;
            wsync2_r <= wsync1_r;
            wq_r     <= wsync2_r;
            rsync1_r <= rd_tog_r;
            rsync2_r <= rsync1_r;
            rq_r     <= rsync2_r;
            if (rd_event)
            begin
                rd_data_c_r  <= mem[rd_index_r];
                rd_ack_tog_r <= ~rd_ack_tog_r;
            end
        end
    end

    // Register array; a bus write wins over a local write in the same cycle
    always_ff @(posedge clk)
    begin
        if (clk_en)
        begin
            if (wr_event)
                mem[wr_index_r] <= wr_data_r;
            else if (user_we)
                mem[user_index] <= user_wdata;
        end
    end

    // Local read port and write notices
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            user_rdata   <= 8'h00;
            bus_wr_pulse <= 1'h0;
            bus_wr_index <= 8'h00;
            bus_wr_data  <= 8'h00;
        end
        else if (clk_en)
        begin
            user_rdata   <= mem[user_index];
            bus_wr_pulse <= wr_event;
            if (wr_event)
            begin
                bus_wr_index <= wr_index_r;
                bus_wr_data  <= wr_data_r;
            end
        end
    end

endmodule

// *** src/i2c_link_pkg.sv ***
package i2c_link_pkg;

    // Clock rates of the two sides
    localparam int CLK_PERIOD_NS  = 5;
    localparam int LINK_PERIOD_NS = 125;

    // Spikes up to this width never reach the protocol logic
    localparam int SPIKE_MAX_NS = 50;

    // Highest bus clock rate of each mode
    localparam int STD_SCL_MAX_KHZ  = 100;
    localparam int FAST_SCL_MAX_KHZ = 400;

    // Least length of one quarter of a bus bit, set by hold and low times
    localparam int STD_PHASE_NS  = 4700;
    localparam int FAST_PHASE_NS = 650;

    // Least times round up to whole cycles
    function automatic int ceil_cycles(input int ns, input int period_ns);
        return (ns + period_ns - 1) / period_ns;
    endfunction

    localparam logic [11:0] STD_PHASE_CYC  = 12'(ceil_cycles(STD_PHASE_NS, CLK_PERIOD_NS));
    localparam logic [11:0] FAST_PHASE_CYC = 12'(ceil_cycles(FAST_PHASE_NS, CLK_PERIOD_NS));

    // Slave address: six fixed upper bits, the pin gives the last one
    localparam logic [5:0] ADDR_UPPER = 6'h10;
    localparam logic [7:0] PTR_RESET  = 8'h00;
    localparam int         REG_COUNT  = 256;

    // Byte-level commands of the master end
    typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} op_type;

    function automatic logic [6:0] own_address(input logic lsb);
        return {ADDR_UPPER, lsb};
    endfunction

endpackage

// *** src/i2c_link_if.sv ***
interface i2c_link_if;

    // Open-drain drivers: an enable pulls the wire to the output level
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;

    // Board straps driven by the master's board
    logic interface_select;
    logic serial_select;

    // Resolved wire levels with pull-ups
    logic scl;
    logic sda;

    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        output interface_select,
        output serial_select,
        input  scl,
        input  sda
    );

    modport device (
        output dev_sda_o,
        output dev_sda_oe,
        input  scl,
        input  sda,
        input  interface_select,
        input  serial_select
    );

endinterface

// *** src/pin_filter.sv ***
module pin_filter (
    // Sampling clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Raw pin and its filtered level
    input  wire logic din,
    output logic      dout
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Two-flop synchroniser, then two agreeing samples; a spike shorter
    // than one sample period can show in one sample only
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r <= 1'h1;
            s2_r <= 1'h1;
            s3_r <= 1'h1;
            dout <= 1'h1;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                dout <= s2_r;
        end
    end

endmodule

// *** src/i2c_master_end.sv ***
module i2c_master_end
    import i2c_link_pkg::*;
(
    // Bus pins
    i2c_link_if.host link,
    // Clock, reset and freeze
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Rate select: high for fast mode
    input  wire logic       fast_mode,
    // Command port
    input  wire logic       cmd_valid,
    input  wire op_type     cmd_op,
    input  wire logic [7:0] cmd_data,
    input  wire logic       cmd_nack,
    output logic            cmd_ready,
    // Result port
    output logic            done,
    output logic      [7:0] rx_data,
    output logic            ack_seen
);

    typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} host_state_type;

    host_state_type       state_r;
    logic           [1:0] phase_r;
    logic          [11:0] qcnt_r;
    logic          [11:0] phase_len;
    logic           [3:0] bit_r;
    logic           [8:0] tx_r;
    logic           [8:0] rx_r;
    logic                 scl_low_r;
    logic                 sda_low_r;
    logic                 sda_s1_r;
    logic                 sda_s2_r;
    logic                 tick;
    logic                 last_phase;
    logic                 op_end;
    logic                 want_scl_low;
    logic                 want_sda_low;

    // Straps select the two-wire port of the far end
    assign link.interface_select = 1'h0;
    assign link.serial_select    = 1'h1;
    assign link.host_scl_o       = 1'h0;
    assign link.host_sda_o       = 1'h0;
    assign link.host_scl_oe      = scl_low_r;
    assign link.host_sda_oe      = sda_low_r;

    // Quarter-bit timing; all four quarters have one length, which keeps hold and setup times
    assign phase_len  = fast_mode ? FAST_PHASE_CYC : STD_PHASE_CYC;
    assign tick       = qcnt_r == 12'h000;
    assign last_phase = tick & (phase_r == 2'h3);
    assign op_end     = last_phase & ((state_r != H_BYTE) | (bit_r == 4'h8));

    // Wire levels per phase; byte data moves only while the clock is low
    assign want_scl_low = (state_r == H_STOP) ? (phase_r == 2'h0) :
                          (phase_r == 2'h0) | (phase_r == 2'h3);
    assign want_sda_low = (state_r == H_START) ? (phase_r >= 2'h2) :
                          (state_r == H_STOP)  ? (phase_r <= 2'h1) :
                          ~tx_r[8];

    // Data line readback passes two flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sda_s1_r <= 1'h1;
            sda_s2_r <= 1'h1;
        end
        else if (clk_en)
        begin
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    // Command sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r   <= H_IDLE;
            phase_r   <= 2'h0;
            qcnt_r    <= 12'h000;
            bit_r     <= 4'h0;
            tx_r      <= 9'h1FF;
            rx_r      <= 9'h000;
            scl_low_r <= 1'h0;
            sda_low_r <= 1'h0;
            cmd_ready <= 1'h1;
            done      <= 1'h0;
            rx_data   <= 8'h00;
            ack_seen  <= 1'h0;
        end
        else if (clk_en)
        begin
            done <= 1'h0;
            if (state_r == H_IDLE)
            begin
                if (cmd_valid & cmd_ready)
                begin
                    state_r   <= (cmd_op == OP_START) ? H_START : (cmd_op == OP_STOP) ? H_STOP : H_BYTE;
                    phase_r   <= 2'h0;
                    qcnt_r    <= phase_len;
                    bit_r     <= 4'h0;
                    // Read releases data and answers ack or nack in the ninth bit
                    tx_r      <= (cmd_op == OP_READ) ? {8'hFF, cmd_nack} : {cmd_data, 1'h1};
                    cmd_ready <= 1'h0;
                end
            end
            else
            begin
                scl_low_r <= want_scl_low;
                sda_low_r <= want_sda_low;
                qcnt_r    <= tick ? phase_len : qcnt_r - 12'h001;
                if (tick)
                    phase_r <= phase_r + 2'h1;
                if (tick & (phase_r == 2'h2) & (state_r == H_BYTE))
                    rx_r <= {rx_r[7:0], sda_s2_r};
                if (last_phase & (state_r == H_BYTE) & (bit_r != 4'h8))
                begin
                    bit_r <= bit_r + 4'h1;
                    tx_r  <= {tx_r[7:0], 1'h1};
                end
                if (op_end)
                begin
                    state_r   <= H_IDLE;
                    cmd_ready <= 1'h1;
                    done      <= 1'h1;
                    if (state_r == H_BYTE)
                    begin
                        rx_data  <= rx_r[8:1];
                        ack_seen <= ~rx_r[0];
                    end
                end
            end
        end
    end

endmodule

// *** test/i2c_link_chk.sv ***
module i2c_link_chk (
    // Bus clock, reset
    input wire logic link_clk,
    input wire logic rst_b,
    // Core supply level at the device
    input wire logic core_supply,
    // Drivers, wires
    input wire logic host_scl_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic interface_select,
    input wire logic serial_select,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge link_clk);
    endclocking
    default disable iff (!rst_b);
    // Device data moves only in the low phase, else it fakes a start or stop
    a_no_stretch: assert property (!scl |-> host_scl_oe) else $error("clock held");
    a_high_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("moved");
    a_ack_low: assert property ($rose(dev_sda_oe) |-> !scl && !sda) else $error("late pull");
    a_open_drain: assert property (dev_sda_oe |-> !dev_sda_o) else $error("drove high");
    // Filter latency is about five samples, so eight leave margin
    a_off_released: assert property (!core_supply [*8] |-> !dev_sda_oe) else $error("driven while off");
    a_quiet_start: assert property ($fell(sda) && scl |=> !dev_sda_oe [*8]) else $error("early");
    a_quiet_stop: assert property ($rose(sda) && scl |=> !dev_sda_oe [*8]) else $error("no idle");
    a_bus_free: assert property ($rose(sda) && scl |=> (scl && sda) [*8]) else $error("busy");
    a_straps: assert property (!interface_select && serial_select) else $error("straps");
    // Main traffic seen
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
endmodule

// *** test/i2c_register_access_slave_tb.sv ***
module i2c_register_access_slave_tb
    import i2c_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, link_clk = 1'b0, rst_b, pin, fast_mode, cmd_valid, cmd_nack, user_we;
    logic       cmd_ready, done, ack_seen, wr_pulse;
    logic       core = 1'b1;
    logic [7:0] cmd_data, user_index, user_wdata, rx_data, user_rdata, bus_wr_index, bus_wr_data, a, d0, d1, u;
    op_type     cmd_op;
    int         n_fail = 0, samples_checked = 0, n_wr = 0;
    // Link clock is offset; its period is 25 clk periods, so its edges keep a fixed phase to clk
    initial forever #2.5 clk = ~clk;
    initial #37 forever #62.5 link_clk = ~link_clk;
    i2c_link_if link ();
    i2c_master_end i2c_master_end_i (.link, .clk, .rst_b, .clk_en(1'b1), .fast_mode, .cmd_valid, .cmd_op,
        .cmd_data, .cmd_nack, .cmd_ready, .done, .rx_data, .ack_seen);
    i2c_slave_end i2c_slave_end_i (.link, .link_clk, .clk, .rst_b, .clk_en(1'b1), .address_lsb_pin(pin),
        .core_supply(core), .interface_supply(1'b1), .user_we, .user_index, .user_wdata, .user_rdata,
        .bus_wr_pulse(wr_pulse), .bus_wr_index, .bus_wr_data);
    i2c_link_chk i2c_link_chk_i (.link_clk, .rst_b, .core_supply(core), .host_scl_oe(link.host_scl_oe),
        .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe), .interface_select(link.interface_select),
        .serial_select(link.serial_select), .scl(link.scl), .sda(link.sda));
    // Bus writes that reached the array
    always @(posedge clk) if (wr_pulse === 1'b1) n_wr <= n_wr + 1;
    // Address byte on the wire: fixed upper bits, pin, direction
    function automatic logic [7:0] abyte(input logic lsb, input logic rd);
        return {6'h10, lsb, rd};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Valid drops at the edge that takes it; a hang is cut short
    task automatic op(input op_type o, input logic [7:0] d = 8'h00, input logic nk = 1'b0);
        int i;
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_data <= d;
        cmd_nack <= nk;
        for (i = 0; i < 40000; i++)
        begin
            @(posedge clk);
            if (cmd_ready === 1'b1 && cmd_valid === 1'b1) cmd_valid <= 1'b0;
            if (done === 1'b1) break;
        end
        if (i == 40000)
        begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic send(input logic [7:0] d);
        op(OP_WRITE, d);
        check(8'(ack_seen), 8'h01);
    endtask
    task automatic open_at();
        op(OP_START);
        send(abyte(pin, 1'b0));
        send(a);
    endtask
    // Wrong address at standard rate, then burst write and read at fast rate
    initial
    begin
        rst_b = 1'b0;
        {fast_mode, cmd_valid, cmd_nack, user_we, cmd_data, user_index, user_wdata} = '0;
        cmd_op = OP_START;
        void'($urandom(32'he4bb));
        {pin, a, d0, d1, u} = 33'({$urandom, $urandom});
        repeat (3) @(posedge link_clk);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (400) @(posedge clk);
        check({6'h0, link.scl, link.sda}, 8'h03);
        op(OP_START);
        op(OP_WRITE, abyte(~pin, 1'b0));
        check(8'(ack_seen), 8'h00);
        check(rx_data, abyte(~pin, 1'b0));
        op(OP_STOP);
        fast_mode <= 1'b1;
        // Own address but core supply off: no answer; power is back before the next start
        core <= 1'b0;
        op(OP_START);
        op(OP_WRITE, abyte(pin, 1'b0));
        check(8'(ack_seen), 8'h00);
        core <= 1'b1;
        open_at();
        send(d0);
        send(d1);
        op(OP_STOP);
        check(bus_wr_index, a + 8'h01);
        check(bus_wr_data, d1);
        check(8'(n_wr), 8'h02);
        user_we <= 1'b1;
        user_index <= a + 8'h02;
        user_wdata <= u;
        @(posedge clk);
        user_we <= 1'b0;
        user_index <= a;
        repeat (3) @(posedge clk);
        check(user_rdata, d0);
        open_at();
        op(OP_START);
        send(abyte(pin, 1'b1));
        op(OP_READ);
        check(rx_data, d0);
        op(OP_READ);
        check(rx_data, d1);
        op(OP_READ, 8'h00, 1'b1);
        check(rx_data, u);
        op(OP_STOP);
        check({6'h0, link.scl, link.sda}, 8'h03);
        conclude();
    end
endmodule
